// File: core/contactless_rx_status_regs.sv
// Receiver status, bit control, collision and timer run-control registers.
// Assumes an APB master on pclk and a receive decoder giving one bit per
// strobe, same clock domain.
`default_nettype none
module contactless_rx_status_regs
    import rx_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic classic_auth_command,
    input wire logic tx_start,
    input wire logic tx_begin,
    input wire logic tx_done,
    input wire logic rx_begin,
    input wire logic rx_start,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_bit_collision,
    input wire logic rx_end,
    input wire logic [3:0] timer_stop,
    output logic cipher_active,
    output logic [3:0] timer_running,
    output logic bit_oriented,
    output logic store_valid,
    output logic [2:0] store_pos,
    output logic store_bit,
    output logic store_byte_next,
    output logic integrity_error,
    output logic collision_detected,
    output logic irq
);
    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic [7:0] wbyte;
    logic [9:0] waddr;
    assign wr_en = psel && penable && pwrite && paddr[1:0] == 2'b00;
    assign rd_en = psel && penable && !pwrite;
    assign wbyte = pwdata[7:0];
    assign waddr = paddr[11:2];
    assign pready = 1'b1;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
        hit = (a == {2'b00, r[9:2]});
    endfunction

    logic mapped;
    assign mapped = hit(waddr, ADDR_LINK_STATUS)
        || hit(waddr, ADDR_RX_BIT_CONTROL)
        || hit(waddr, ADDR_COLLISION_POSITION)
        || hit(waddr, ADDR_TIMER_RUN_CONTROL)
        || hit(waddr, ADDR_IRQ_STATUS) || hit(waddr, ADDR_IRQ_MASK)
        || paddr[1:0] != 2'b00;
    assign pslverr = psel && penable && !(mapped && paddr[1:0] == 2'b00);

    // ----------------------------------------------------------------
    // Link state machine
    // ----------------------------------------------------------------
    link_state_t state_r;
    logic [2:0] link_state;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: if (tx_start) state_r <= ST_TX_WAIT;
                    else if (rx_start) state_r <= ST_WAIT_DATA;
                ST_TX_WAIT: if (tx_begin) state_r <= ST_TX;
                ST_TX: if (tx_done) state_r <= ST_RX_WAIT;
                ST_RX_WAIT: if (rx_start) state_r <= ST_WAIT_DATA;
                ST_WAIT_DATA: if (rx_begin) state_r <= ST_RX;
                ST_RX: if (rx_end) state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end
    always_comb begin
        case (state_r)
            ST_TX_WAIT: link_state = CODE_TX_WAIT;
            ST_TX: link_state = CODE_TX;
            ST_RX_WAIT: link_state = CODE_RX_WAIT;
            ST_WAIT_DATA: link_state = CODE_WAIT_DATA;
            ST_RX: link_state = CODE_RX;
            default: link_state = CODE_IDLE;
        endcase
    end
    logic receiving;
    assign receiving = (state_r == ST_RX);

    // ----------------------------------------------------------------
    // Cipher active bit
    // ----------------------------------------------------------------
    logic cipher_r;
    logic cipher_clr;
    assign cipher_clr = wr_en && hit(waddr, ADDR_LINK_STATUS)
        && !wbyte[CIPHER_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cipher_r <= 1'b0;
        end else if (classic_auth_command) begin
            cipher_r <= 1'b1;
        end else if (cipher_clr) begin
            cipher_r <= 1'b0;
        end
    end
    assign cipher_active = cipher_r;

    // ----------------------------------------------------------------
    // Receiver bit control
    // ----------------------------------------------------------------
    logic keep_r;
    logic [2:0] align_r;
    logic integ_coll_r;
    logic [2:0] last_bits_r;
    logic [2:0] pos_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keep_r <= RST_RX_BIT_CONTROL[KEEP_BIT];
            align_r <= RST_RX_BIT_CONTROL[ALIGN_LSB +: 3];
            integ_coll_r <= RST_RX_BIT_CONTROL[INTEG_COLL_BIT];
        end else if (wr_en && hit(waddr, ADDR_RX_BIT_CONTROL)) begin
            keep_r <= wbyte[KEEP_BIT];
            align_r <= wbyte[ALIGN_LSB +: 3];
            integ_coll_r <= wbyte[INTEG_COLL_BIT];
        end
    end
    assign bit_oriented = (align_r != 3'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_bits_r <= RST_RX_BIT_CONTROL[2:0];
        end else if (rx_begin) begin
            last_bits_r <= 3'h0;
        end else if (rx_end && receiving && bit_oriented) begin
            last_bits_r <= pos_r;
        end else if (wr_en && hit(waddr, ADDR_RX_BIT_CONTROL)) begin
            last_bits_r <= wbyte[2:0];
        end
    end

    // ----------------------------------------------------------------
    // Bit placement and collision tracking
    // ----------------------------------------------------------------
    logic coll_seen_r;
    logic [6:0] bit_cnt_r;
    logic cnt_ovf_r;
    logic [6:0] coll_pos_r;
    logic coll_valid_r;
    logic coll_det_r;
    logic integ_r;
    logic take_bit;
    logic first_coll;
    assign take_bit = receiving && rx_bit_valid;
    assign first_coll = take_bit && rx_bit_collision && !coll_seen_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_r <= 3'h0;
            bit_cnt_r <= 7'h00;
            cnt_ovf_r <= 1'b0;
            coll_seen_r <= 1'b0;
        end else if (rx_begin) begin
            pos_r <= align_r;
            bit_cnt_r <= {4'h0, align_r};
            cnt_ovf_r <= 1'b0;
            coll_seen_r <= 1'b0;
        end else if (take_bit) begin
            pos_r <= pos_r + 3'h1;
            if (bit_cnt_r == 7'h7F) begin
                cnt_ovf_r <= 1'b1;
            end
            bit_cnt_r <= bit_cnt_r + 7'h01;
            if (rx_bit_collision) begin
                coll_seen_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_valid <= 1'b0;
            store_pos <= 3'h0;
            store_bit <= 1'b0;
            store_byte_next <= 1'b0;
        end else begin
            store_valid <= take_bit;
            store_pos <= pos_r;
            store_byte_next <= take_bit && (pos_r == 3'h7);
            store_bit <= rx_bit && !(coll_seen_r && !keep_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coll_pos_r <= RST_COLLISION[6:0];
            coll_valid_r <= RST_COLLISION[VALID_BIT];
            coll_det_r <= 1'b0;
            integ_r <= 1'b0;
        end else if (rx_begin) begin
            coll_pos_r <= 7'h00;
            coll_valid_r <= 1'b0;
            coll_det_r <= 1'b0;
            integ_r <= 1'b0;
        end else if (first_coll) begin
            coll_det_r <= 1'b1;
            coll_pos_r <= bit_cnt_r;
            coll_valid_r <= !cnt_ovf_r
                && (bit_cnt_r <= COLL_INDEX_MAX);
            if (integ_coll_r) begin
                integ_r <= 1'b1;
            end
        end
    end
    assign collision_detected = coll_det_r;
    assign integrity_error = integ_r;

    // ----------------------------------------------------------------
    // Timer run control
    // ----------------------------------------------------------------
    logic [3:0] run_r;
    logic [3:0] wmask;
    assign wmask = (wr_en && hit(waddr, ADDR_TIMER_RUN_CONTROL))
        ? wbyte[3:0] : 4'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= RST_RUN;
        end else begin
            run_r <= (wmask & wbyte[RUN_LSB +: 4])
                | (~wmask & run_r & ~timer_stop);
        end
    end
    assign timer_running = run_r;

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic [3:0] ev;
    logic [3:0] clr;
    assign ev = {cipher_clr && cipher_r, rx_end && receiving,
        first_coll && integ_coll_r, first_coll};
    assign clr = (wr_en && hit(waddr, ADDR_IRQ_STATUS)) ? wbyte[3:0] : 4'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= RST_IRQ;
        end else begin
            irq_stat_r <= ev | (irq_stat_r & ~clr);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= RST_IRQ;
        end else if (wr_en && hit(waddr, ADDR_IRQ_MASK)) begin
            irq_mask_r <= wbyte[3:0];
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [7:0] rbyte;
    always_comb begin
        rbyte = 8'h00;
        if (paddr[1:0] != 2'b00) begin
            rbyte = 8'h00;
        end else if (hit(waddr, ADDR_LINK_STATUS)) begin
            rbyte = {2'b00, cipher_r, 2'b00, link_state};
        end else if (hit(waddr, ADDR_RX_BIT_CONTROL)) begin
            rbyte = {keep_r, align_r, integ_coll_r, last_bits_r};
        end else if (hit(waddr, ADDR_COLLISION_POSITION)) begin
            rbyte = {coll_valid_r, coll_pos_r};
        end else if (hit(waddr, ADDR_TIMER_RUN_CONTROL)) begin
            rbyte = {run_r, 4'h0};
        end else if (hit(waddr, ADDR_IRQ_STATUS)) begin
            rbyte = {4'h0, irq_stat_r};
        end else if (hit(waddr, ADDR_IRQ_MASK)) begin
            rbyte = {4'h0, irq_mask_r};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rbyte};
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_cipher_clear: assert property (@(posedge pclk) disable iff (!presetn)
        cipher_clr && !classic_auth_command |=> !cipher_active)
        else $error("cipher not cleared");
    a_cipher_set_only: assert property (@(posedge pclk)
        disable iff (!presetn)
        $rose(cipher_active) |-> $past(classic_auth_command))
        else $error("cipher set without auth");
    a_state_code: assert property (@(posedge pclk) disable iff (!presetn)
        rx_begin && state_r == ST_WAIT_DATA |=>
        link_state == CODE_RX && link_state != 3'h4)
        else $error("bad link state code");
    a_zero_fill: assert property (@(posedge pclk) disable iff (!presetn)
        take_bit && coll_seen_r && !keep_r |=> !store_bit)
        else $error("bit after collision not zeroed");
    a_first_pos: assert property (@(posedge pclk) disable iff (!presetn)
        rx_begin ##1 (take_bit && !rx_begin) |=>
        store_pos == $past(align_r, 2))
        else $error("first bit misplaced");
    a_mode_sel: assert property (@(posedge pclk) disable iff (!presetn)
        bit_oriented == (align_r != 3'h0))
        else $error("mode select wrong");
    a_integ_coll: assert property (@(posedge pclk) disable iff (!presetn)
        first_coll && integ_coll_r && !rx_begin |=> integrity_error)
        else $error("collision not integrity error");
    a_last_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rx_begin |=> last_bits_r == 3'h0)
        else $error("last bits not cleared");
    a_coll_record: assert property (@(posedge pclk) disable iff (!presetn)
        first_coll && !rx_begin |=> collision_detected
        && coll_pos_r == $past(bit_cnt_r))
        else $error("collision position wrong");
    a_valid_range: assert property (@(posedge pclk) disable iff (!presetn)
        coll_valid_r |-> coll_pos_r <= COLL_INDEX_MAX)
        else $error("valid flag out of range");
    a_run_mask: assert property (@(posedge pclk) disable iff (!presetn)
        wmask == 4'h0 && timer_stop == 4'h0 |=> $stable(timer_running))
        else $error("unmasked run bit changed");
    c_collision: cover property (@(posedge pclk) first_coll);
    c_bit_frame: cover property (@(posedge pclk)
        rx_end && receiving && bit_oriented);
    c_timer_start: cover property (@(posedge pclk) $rose(timer_running[0]));
    c_irq: cover property (@(posedge pclk) $rose(irq));
endmodule
`default_nettype wire

// File: core/rx_status_pkg.sv
// Package for the receiver status and bit-control register group.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
//
// What this block does
// - The cipher-active bit is set only by the classic authentication command, and writing it to zero turns the cipher off.
// - The link state field shows idle 000b, transmit wait 001b, transmitting 011b, receive wait 101b, wait for data 110b, receiving 111b, never 100b.
// - With keep-bits-after-collision at zero, every bit received after a collision is stored as zero.
// - The first received bit lands at the first-bit position, and later bits fill upward into the next byte.
// - A first-bit position of zero means byte-oriented reception, any other value bit-oriented.
// - While collision-as-integrity-error is set, a collision raises the integrity error flag.
// - In bit-oriented reception the last-valid-bits field gives the valid bit count of the final byte, zero meaning a whole byte;
//   otherwise it is cleared at frame start and then holds any value written to it.
// - The collision-position-valid flag is one only when the position field holds a valid position.
// - The collision position is the zero-based index of the first collided data bit, covering 8 bytes up to 3Fh.
// - A nonzero first-bit position is added into the reported collision position.
// - On a timer run-control write, bits 3..0 enable the update of bits 7..4.
// - Each upper timer run-control bit shows its timer running, and a masked write starts or stops it.
// - When a collision is detected, the first collision position is recorded.
`default_nettype none
package rx_status_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses (index times four)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_LINK_STATUS = 8'h0B;
    localparam logic [7:0] IDX_RX_BIT_CONTROL = 8'h0C;
    localparam logic [7:0] IDX_COLLISION_POSITION = 8'h0D;
    localparam logic [7:0] IDX_TIMER_RUN_CONTROL = 8'h0E;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
    localparam logic [9:0] ADDR_LINK_STATUS = {IDX_LINK_STATUS, 2'b00};
    localparam logic [9:0] ADDR_RX_BIT_CONTROL = {IDX_RX_BIT_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_COLLISION_POSITION =
        {IDX_COLLISION_POSITION, 2'b00};
    localparam logic [9:0] ADDR_TIMER_RUN_CONTROL =
        {IDX_TIMER_RUN_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CIPHER_BIT = 5;
    localparam int KEEP_BIT = 7;
    localparam int ALIGN_LSB = 4;
    localparam int INTEG_COLL_BIT = 3;
    localparam int VALID_BIT = 7;
    localparam int RUN_LSB = 4;
    localparam logic [6:0] COLL_INDEX_MAX = 7'h3F;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_RX_BIT_CONTROL = 8'h00;
    localparam logic [7:0] RST_COLLISION = 8'h00;
    localparam logic [3:0] RST_RUN = 4'h0;
    localparam logic [3:0] RST_IRQ = 4'h0;
    // Interrupt status bits
    localparam int EV_COLL = 0;
    localparam int EV_INTEG = 1;
    localparam int EV_RX_END = 2;
    localparam int EV_CIPHER_OFF = 3;
    // ----------------------------------------------------------------
    // Link states, one-hot, with their reported codes
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_TX_WAIT = 6'b000010,
        ST_TX = 6'b000100,
        ST_RX_WAIT = 6'b001000,
        ST_WAIT_DATA = 6'b010000,
        ST_RX = 6'b100000
    } link_state_t;
    localparam logic [2:0] CODE_IDLE = 3'h0;
    localparam logic [2:0] CODE_TX_WAIT = 3'h1;
    localparam logic [2:0] CODE_TX = 3'h3;
    localparam logic [2:0] CODE_RX_WAIT = 3'h5;
    localparam logic [2:0] CODE_WAIT_DATA = 3'h6;
    localparam logic [2:0] CODE_RX = 3'h7;
endpackage
`default_nettype wire

// File: bench/card_model.sv
// Card model: sends one received frame, bit by bit, into the block.
// Assumes pclk is shared and send is called right after a rising edge.
`default_nettype none
module card_model (
    input wire logic pclk,
    output logic rx_begin = 1'b0,
    output logic rx_bit_valid = 1'b0,
    output logic rx_bit = 1'b0,
    output logic rx_bit_collision = 1'b0,
    output logic rx_end = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Frame: start, data bits with at most one collided bit, gaps when slow
    // --------------------------------------------------------------
    task automatic send(input logic [79:0] d, input int n, input int c,
        input bit slow);
        rx_begin <= 1'b1;
        @(posedge pclk);
        rx_begin <= 1'b0;
        for (int i = 0; i < n; i++) begin
            rx_bit_valid <= 1'b1;
            rx_bit <= d[i];
            rx_bit_collision <= (i == c);
            @(posedge pclk);
            if (slow && i[0]) begin
                rx_bit_valid <= 1'b0;
                rx_bit_collision <= 1'b0;
                rx_bit <= ~d[i];
                @(posedge pclk);
            end
        end
        rx_bit_valid <= 1'b0;
        rx_bit_collision <= 1'b0;
        rx_bit <= ~rx_bit;
        rx_end <= 1'b1;
        @(posedge pclk);
        rx_end <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// File: bench/contactless_rx_status_regs_tb.sv
// Testbench for the receiver status register group.
// Assumes the card model drives the receive side; APB master is here.
`default_nettype none
module contactless_rx_status_regs_tb
    import rx_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic classic_auth_command = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] ev = 4'h0;
    logic [3:0] timer_stop = 4'h0;
    logic [31:0] prdata;
    logic [3:0] timer_running;
    logic [2:0] store_pos;
    logic pready, pslverr, rx_begin, rx_bit_valid, rx_bit, rx_bit_collision;
    logic rx_end, cipher_active, bit_oriented, store_valid, store_bit;
    logic store_byte_next, integrity_error, collision_detected, irq;
    int failures = 0;
    int total_checks = 0;
    integer seed = 65915;
    logic [64:0] rq[$];
    logic [5:0] sq[$];
    logic [2:0] cd[4] = '{CODE_WAIT_DATA, CODE_RX_WAIT, CODE_TX, CODE_TX_WAIT};
    logic [9:0] ra[6] = '{ADDR_LINK_STATUS, ADDR_RX_BIT_CONTROL,
        ADDR_COLLISION_POSITION, ADDR_TIMER_RUN_CONTROL, ADDR_IRQ_STATUS,
        ADDR_IRQ_MASK};
    always #5 pclk = ~pclk;
    contactless_rx_status_regs u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .classic_auth_command,
        .tx_start(ev[3]), .tx_begin(ev[2]), .tx_done(ev[1]),
        .rx_start(ev[0]), .rx_begin, .rx_bit_valid, .rx_bit,
        .rx_bit_collision, .rx_end, .timer_stop, .cipher_active,
        .timer_running, .bit_oriented, .store_valid, .store_pos,
        .store_bit, .store_byte_next, .integrity_error,
        .collision_detected, .irq
    );
    card_model u_card (.pclk, .rx_begin, .rx_bit_valid, .rx_bit,
        .rx_bit_collision, .rx_end);
    // --------------------------------------------------------------
    // Checking and bus tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic [9:0] a, input logic w,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            failures++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e,
        input logic [31:0] m, input logic err = 1'b0);
        rq.push_back({m, err, e});
        apb(a, 1'b0, 32'h0);
    endtask
    task automatic frame(input logic [2:0] al, input int n, input int c,
        input logic keep, input logic ig, input bit slow, input bit go);
        logic [79:0] d;
        logic [2:0] p;
        logic [31:0] e;
        logic [31:0] m;
        int ci;
        bit hit;
        d = {$random(seed), $random(seed), 16'($random(seed))};
        if (c < 80) d[c] = 1'b0;
        for (int i = 0; i < n; i++) begin
            p = al + 3'(i);
            sq.push_back({1'b1, p == 3'h7, p, (i > c && !keep) ? 1'b0 : d[i]});
        end
        apb(ADDR_RX_BIT_CONTROL, 1'b1, {24'h0, keep, al, ig, 3'h0});
        if (go) begin
            ev[0] <= 1'b1;
            @(posedge pclk);
            ev[0] <= 1'b0;
            @(posedge pclk);
        end
        fork
            u_card.send(d, n, c, slow);
            begin
                repeat (3) @(posedge pclk);
                rd(ADDR_LINK_STATUS, {29'h0, CODE_RX}, 32'h07);
            end
        join
        hit = c < n;
        ci = al + c;
        e = {24'h0, keep, al, ig, (al != 3'h0) ? al + 3'(n) : 3'h0};
        rd(ADDR_RX_BIT_CONTROL, e, 32'hFF);
        e = {24'h0, hit && ci < 64, 7'(ci)};
        m = (hit && ci < 64) ? 32'hFF : 32'h80;
        rd(ADDR_COLLISION_POSITION, e, m);
        @(negedge pclk);
        e = {28'h0, integrity_error, collision_detected, bit_oriented, irq};
        chk(33'(e), {29'h0, hit && ig, hit, al != 3'h0, 1'b1});
        @(posedge pclk);
        rd(ADDR_IRQ_STATUS, {29'h0, 1'b1, hit && ig, hit}, 32'hFF);
        apb(ADDR_IRQ_STATUS, 1'b1, 32'h0F);
    endtask
    // --------------------------------------------------------------
    // Result watcher: oldest note against each result
    // --------------------------------------------------------------
    always @(posedge pclk) begin
        logic [64:0] r;
        logic [5:0] s;
        logic [5:0] g;
        if (psel && penable && pready && !pwrite) begin
            r = rq.size() > 0 ? rq.pop_front() : '1;
            chk({pslverr, prdata & r[64:33]},
                {r[32], r[31:0] & r[64:33]});
        end
        if (store_valid === 1'b1) begin
            s = sq.size() > 0 ? sq.pop_front() : '0;
            g = {1'b1, store_byte_next, store_pos, store_bit};
            chk(33'(g), 33'(s));
        end
    end
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ra[i]) rd(ra[i], 32'h0, 32'hFF);
        rd(10'h03C, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(ADDR_COLLISION_POSITION, 1'b1, $random(seed));
        apb(ADDR_LINK_STATUS, 1'b1, 32'hFF);
        rd(ADDR_COLLISION_POSITION, 32'h0, 32'hFF);
        rd(ADDR_LINK_STATUS, 32'h0, 32'hFF);
        classic_auth_command <= 1'b1;
        @(posedge pclk);
        classic_auth_command <= 1'b0;
        @(posedge pclk);
        rd(ADDR_LINK_STATUS, 32'h20, 32'hFF);
        apb(ADDR_IRQ_MASK, 1'b1, 32'h0C);
        apb(ADDR_LINK_STATUS, 1'b1, 32'h00);
        rd(ADDR_IRQ_STATUS, 32'h08, 32'hFF);
        @(negedge pclk);
        chk(33'({cipher_active, irq}), 33'h1);
        @(posedge pclk);
        apb(ADDR_IRQ_STATUS, 1'b1, 32'h08);
        apb(ADDR_TIMER_RUN_CONTROL, 1'b1, 32'hFF);
        apb(ADDR_TIMER_RUN_CONTROL, 1'b1, 32'hF0);
        rd(ADDR_TIMER_RUN_CONTROL, 32'hF0, 32'hF0);
        apb(ADDR_TIMER_RUN_CONTROL, 1'b1, 32'h05);
        rd(ADDR_TIMER_RUN_CONTROL, 32'hA0, 32'hF0);
        timer_stop <= 4'h8;
        @(posedge pclk);
        timer_stop <= 4'h0;
        @(negedge pclk);
        chk(33'({timer_running, irq}), 33'h04);
        @(posedge pclk);
        for (int k = 3; k >= 0; k--) begin
            ev[k] <= 1'b1;
            @(posedge pclk);
            ev[k] <= 1'b0;
            @(posedge pclk);
            rd(ADDR_LINK_STATUS, {29'h0, cd[k]}, 32'h07);
        end
        frame(3'h0, 16, 999, 1'b0, 1'b0, 1'b0, 1'b0);
        frame(3'h4, 11, 3, 1'b0, 1'b1, 1'b1, 1'b1);
        frame(3'h0, 72, 70, 1'b1, 1'b0, 1'b1, 1'b1);
        frame(3'h0, 66, 63, 1'b0, 1'b1, 1'b0, 1'b1);
        repeat (3) @(posedge pclk);
        chk(33'(rq.size() + sq.size()), 33'h0);
        test_done();
    end
endmodule
`default_nettype wire
